/* File: pkg/exc_pkg.sv */
// Constants, types and carriers of the exception entry and frame unit.
// Assumes a single processor clock and a 32-bit Avalon-MM register port.
package exc_pkg;

  // ************************************************
  // State word layout and values
  // ************************************************
  localparam int SR_T1      = 15;
  localparam int SR_T0      = 14;
  localparam int SR_S       = 13;
  localparam int SR_MASK_HI = 10;
  localparam int SR_MASK_LO = 8;
  localparam logic [15:0] SR_RESET = 16'h2700;

  // ************************************************
  // Interrupt acknowledge and vectors
  // ************************************************
  localparam logic [3:0] IACK_SPACE    = 4'hF;
  localparam logic [2:0] LEVEL_NMI     = 3'h7;
  localparam logic [7:0] VEC_SPURIOUS  = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;

  // ************************************************
  // Stack frames
  // ************************************************
  localparam logic [3:0]  FMT_FOUR    = 4'h0;
  localparam logic [3:0]  FMT_SIX     = 4'h2;
  localparam logic [3:0]  FMT_FAULT   = 4'hC;
  localparam logic [31:0] STEP_FOUR   = 32'h0000_0008;
  localparam logic [31:0] STEP_SIX    = 32'h0000_000C;
  localparam logic [31:0] STEP_FAULT  = 32'h0000_0018;
  localparam logic [31:0] SSP_RESET   = 32'h0000_0000;
  localparam logic [7:0]  VERSION_RST = 8'h01;

  // ************************************************
  // Fault status word fields
  // ************************************************
  localparam int FSW_TP  = 15;
  localparam int FSW_MV  = 14;
  localparam int FSW_TR  = 12;
  localparam int FSW_B1  = 11;
  localparam int FSW_B0  = 10;
  localparam int FSW_RR  = 9;
  localparam int FSW_RM  = 8;
  localparam int FSW_IN  = 7;
  localparam int FSW_RW  = 6;
  localparam int FSW_LG  = 5;
  localparam int FSW_SZH = 4;
  localparam int FSW_SZL = 3;
  localparam int FSW_FCH = 2;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ************************************************
  // Register map (byte addresses)
  // ************************************************
  localparam logic [4:0] REG_STATE   = 5'h00;
  localparam logic [4:0] REG_SSP     = 5'h04;
  localparam logic [4:0] REG_VERSION = 5'h08;
  localparam logic [4:0] REG_STATUS  = 5'h0C;
  localparam logic [4:0] REG_FSW     = 5'h10;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_IACK    = 3'b001,
    ST_PUSH    = 3'b010,
    ST_RTE     = 3'b011,
    ST_REWRITE = 3'b100,
    ST_HALT    = 3'b101
  } unit_state_e;

  typedef enum logic [2:0] {
    RES_NONE     = 3'b000,
    RES_FOUR     = 3'b001,
    RES_SIX      = 3'b010,
    RES_FAULT    = 3'b011,
    RES_FORMAT   = 3'b100,
    RES_BUSERR   = 3'b101
  } rte_result_e;

  typedef struct packed {
    logic [7:0]  vector;
    logic [31:0] pc;
    logic [15:0] sr;
  } push_frame_s;

  typedef struct packed {
    logic [3:0]  format;
    logic [15:0] sr;
    logic [31:0] pc;
    logic [15:0] fsw;
    logic [15:0] word14;
    logic        accessible;
  } rte_frame_s;

  typedef struct packed {
    logic       exc_class;
    logic       multi_register_move_xfer;
    logic       multi_register_move_prefetch;
    logic       prefetch;
    logic       read;
    logic       rmw;
    logic       released_write;
    logic       long_op;
    logic [1:0] size;
    logic [2:0] cycle_space_code;
    logic       trace_pend;
    logic       brk_ext;
    logic       brk_int;
  } fault_info_s;

  typedef struct packed {
    logic       read;
    logic [1:0] size;
    logic [2:0] cycle_space_code;
  } rerun_cycle_s;

endpackage : exc_pkg

/* File: rtl/exception_frame_unit.sv */
// Interrupt recognition and vectoring, exception return frame checks and
// fault status word formation, with an Avalon-MM register port.
// Assumes the bus controller runs acknowledge, stacking and rewrite cycles.
//
// Notes on behaviour
// - Request lines pass a synchroniser; a level counts once stable two clocks.
// - Requests stay pending and are checked only at instruction boundaries.
// - Entry copies state word, sets supervisor, clears trace, raises mask.
// - Acknowledge cycle uses space F with the level on the address.
// - Autovector requests give vector 24 plus level, 25 to 31.
// - Bus fault on acknowledge gives spurious vector 24.
// - Vector, return address and saved state word are pushed.
// - Level seven fires on entering seven or mask dropping from seven.
// - Return from four-word frame adds 8, six-word frame adds 12.
// - Fault frames need valid format and matching version byte.
// - Invalid frame is format error, unreachable fault frame is bus error, else restore.
// - Frames from faults in exception stacking are rewritten; error halts.
// - Errors build a new frame below, rejected frame untouched.
// - Fault status word has fixed field positions, bit 13 zero.
// - Frame class bit is one only for faults while stacking.
// - Block move transfer sets move bit; its prefetch sets both bits.
// - Pending trace and both breakpoint channels are recorded.
// - Rerun bit marks released write; rerun on return if still set.
// - Locked and prefetch bits are recorded and ignored on restore.
// - Read bit is one for reads, reloaded when rerun is set.
// - Long operand bit set for long operands, ignored on restore.
// - Width codes 00 long, 01 byte, 10 word.
// - Cycle space code copied, reloaded when rerun is set.
// - Levels one to six below or at the mask are ignored.
`timescale 1ns/1ps
module exception_frame_unit (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [7:1]            interrupt_request_lines,
  input  wire logic                  at_boundary,
  input  wire logic [31:0]           next_pc,
  output logic                       iack_req,
  output logic [3:0]                 iack_space,
  output logic [2:0]                 iack_level,
  input  wire logic                  iack_done,
  input  wire logic                  iack_autovector,
  input  wire logic                  iack_bus_fault,
  input  wire logic [7:0]            iack_vector,
  output logic                       push_valid,
  output exc_pkg::push_frame_s       push_frame,
  input  wire logic                  push_ack,
  input  wire logic                  rte_req,
  input  wire exc_pkg::rte_frame_s   rte_frame,
  output logic                       rte_done,
  output exc_pkg::rte_result_e       rte_result,
  output logic [31:0]                restored_pc,
  output logic                       rerun_valid,
  output exc_pkg::rerun_cycle_s      rerun_cycle,
  output logic                       rewrite_req,
  input  wire logic                  rewrite_done,
  input  wire logic                  rewrite_fault,
  output logic                       halted,
  input  wire logic                  fault_req,
  input  wire exc_pkg::fault_info_s  fault_info,
  output logic [15:0]                fault_status_word,
  output logic [15:0]                processor_state_word,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest
);

  // ************************************************
  // State
  // ************************************************
  logic [7:1]               irq_s1, irq_s2, irq_s3, irq_filt;
  logic [2:0]               prev_level, prev_mask;
  logic                     nmi_pending, next_nmi_pending;
  exc_pkg::unit_state_e     state, next_state;
  logic [15:0]              sr, next_sr;
  logic [31:0]              supervisor_stack_pointer, next_ssp;
  logic [7:0]               version, next_version;
  logic [2:0]               pend_level, next_pend_level;
  exc_pkg::push_frame_s     next_push_frame;
  exc_pkg::rte_frame_s      frame, next_frame;
  logic                     next_rte_done, next_rerun_valid;
  exc_pkg::rte_result_e     next_rte_result;
  logic [31:0]              next_restored_pc;
  exc_pkg::rerun_cycle_s    next_rerun_cycle;
  logic [15:0]              next_fsw;
  logic                     bus_ack, next_bus_ack;
  logic [31:0]              next_readdata;
  logic [2:0]               level, mask;
  logic                     take_irq, nmi_set, wr_ok;

  // Three-stage synchroniser; filtered level moves only when stages agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_s1   <= '0;
      irq_s2   <= '0;
      irq_s3   <= '0;
      irq_filt <= '0;
    end else begin
      irq_s1 <= interrupt_request_lines;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      for (int i = 1; i < 8; i++) begin
        if (irq_s2[i] == irq_s3[i]) begin
          irq_filt[i] <= irq_s3[i];
        end
      end
    end
  end

  // Highest active line gives the request level
  always_comb begin
    level = '0;
    for (int i = 1; i < 8; i++) begin
      if (irq_filt[i]) begin
        level = 3'(i);
      end
    end
  end

  // Recognition: level seven by transition, others against the mask
  assign mask     = sr[exc_pkg::SR_MASK_HI:exc_pkg::SR_MASK_LO];
  assign nmi_set  = (level == exc_pkg::LEVEL_NMI) &&
                    ((prev_level != exc_pkg::LEVEL_NMI) ||
                     ((prev_mask == exc_pkg::LEVEL_NMI) && (mask != exc_pkg::LEVEL_NMI)));
  assign take_irq = (state == exc_pkg::ST_IDLE) && at_boundary &&
                    (nmi_pending || ((level != exc_pkg::LEVEL_NMI) && (level > mask)));
  assign wr_ok    = avs_write && bus_ack;

  // ************************************************
  // Next-state logic
  // ************************************************
  always_comb begin
    next_state       = state;
    next_sr          = sr;
    next_ssp         = supervisor_stack_pointer;
    next_version     = version;
    next_pend_level  = pend_level;
    next_push_frame  = push_frame;
    next_frame       = frame;
    next_rte_done    = 1'b0;
    next_rte_result  = rte_result;
    next_restored_pc = restored_pc;
    next_rerun_valid = 1'b0;
    next_rerun_cycle = rerun_cycle;
    next_fsw         = fault_status_word;
    next_nmi_pending = nmi_pending;
    if (take_irq && nmi_pending) begin
      next_nmi_pending = 1'b0;
    end
    if (nmi_set) begin
      next_nmi_pending = 1'b1;
    end
    // Software writes to registers only while the unit is idle
    if (wr_ok && (state == exc_pkg::ST_IDLE) && !take_irq) begin
      case (avs_address)
        exc_pkg::REG_STATE:   next_sr      = avs_writedata[15:0];
        exc_pkg::REG_SSP:     next_ssp     = avs_writedata;
        exc_pkg::REG_VERSION: next_version = avs_writedata[7:0];
        default:              next_sr      = sr;
      endcase
    end
    case (state)
      exc_pkg::ST_IDLE: begin
        if (take_irq) begin
          next_push_frame.sr             = sr;
          next_push_frame.pc             = next_pc;
          next_sr[exc_pkg::SR_S]         = 1'b1;
          next_sr[exc_pkg::SR_T1]        = 1'b0;
          next_sr[exc_pkg::SR_T0]        = 1'b0;
          next_sr[exc_pkg::SR_MASK_HI:exc_pkg::SR_MASK_LO] = nmi_pending ?
                                           exc_pkg::LEVEL_NMI : level;
          next_pend_level                = nmi_pending ? exc_pkg::LEVEL_NMI : level;
          next_state                     = exc_pkg::ST_IACK;
        end else if (rte_req) begin
          next_frame = rte_frame;
          next_state = exc_pkg::ST_RTE;
        end
      end
      exc_pkg::ST_IACK: begin
        if (iack_done) begin
          if (iack_bus_fault) begin
            next_push_frame.vector = exc_pkg::VEC_SPURIOUS;
          end else if (iack_autovector) begin
            next_push_frame.vector = exc_pkg::VEC_AUTO_BASE + {5'h00, pend_level};
          end else begin
            next_push_frame.vector = iack_vector;
          end
          next_state = exc_pkg::ST_PUSH;
        end
      end
      exc_pkg::ST_PUSH: begin
        if (push_ack) begin
          next_ssp   = supervisor_stack_pointer - exc_pkg::STEP_FOUR;
          next_state = exc_pkg::ST_IDLE;
        end
      end
      exc_pkg::ST_RTE: begin
        next_rte_done = 1'b1;
        next_state    = exc_pkg::ST_IDLE;
        if (frame.format == exc_pkg::FMT_FOUR) begin
          next_sr          = frame.sr;
          next_restored_pc = frame.pc;
          next_ssp         = supervisor_stack_pointer + exc_pkg::STEP_FOUR;
          next_rte_result  = exc_pkg::RES_FOUR;
        end else if (frame.format == exc_pkg::FMT_SIX) begin
          next_sr          = frame.sr;
          next_restored_pc = frame.pc;
          next_ssp         = supervisor_stack_pointer + exc_pkg::STEP_SIX;
          next_rte_result  = exc_pkg::RES_SIX;
        end else if ((frame.format == exc_pkg::FMT_FAULT) && !frame.accessible) begin
          next_ssp        = supervisor_stack_pointer - exc_pkg::STEP_FAULT;
          next_rte_result = exc_pkg::RES_BUSERR;
        end else if ((frame.format == exc_pkg::FMT_FAULT) &&
                     (frame.word14[15:8] == version)) begin
          next_sr          = frame.sr;
          next_restored_pc = frame.pc;
          next_ssp         = supervisor_stack_pointer + exc_pkg::STEP_FAULT;
          next_rte_result  = exc_pkg::RES_FAULT;
          // Rerun, read, width and space are reloaded; class bit selects rewrite; other bits ignored
          next_rerun_valid      = frame.fsw[exc_pkg::FSW_RR];
          next_rerun_cycle.read = frame.fsw[exc_pkg::FSW_RW];
          next_rerun_cycle.size = frame.fsw[exc_pkg::FSW_SZH:exc_pkg::FSW_SZL];
          next_rerun_cycle.cycle_space_code = frame.fsw[exc_pkg::FSW_FCH:0];
          if (frame.fsw[exc_pkg::FSW_TP]) begin
            next_rte_done = 1'b0;
            next_state    = exc_pkg::ST_REWRITE;
          end
        end else begin
          next_ssp        = supervisor_stack_pointer - exc_pkg::STEP_FOUR;
          next_rte_result = exc_pkg::RES_FORMAT;
        end
      end
      exc_pkg::ST_REWRITE: begin
        if (rewrite_fault) begin
          next_state = exc_pkg::ST_HALT;
        end else if (rewrite_done) begin
          next_rte_done = 1'b1;
          next_state    = exc_pkg::ST_IDLE;
        end
      end
      exc_pkg::ST_HALT: next_state = exc_pkg::ST_HALT;
      default:          next_state = exc_pkg::ST_IDLE;
    endcase
    // Fault status word captured from the faulted cycle description
    if (fault_req) begin
      next_fsw                                      = '0;
      next_fsw[exc_pkg::FSW_TP]                     = fault_info.exc_class;
      next_fsw[exc_pkg::FSW_MV]                     = fault_info.multi_register_move_xfer |
                                                      fault_info.multi_register_move_prefetch;
      next_fsw[exc_pkg::FSW_TR]                     = fault_info.trace_pend;
      next_fsw[exc_pkg::FSW_B1]                     = fault_info.brk_ext;
      next_fsw[exc_pkg::FSW_B0]                     = fault_info.brk_int;
      next_fsw[exc_pkg::FSW_RR]                     = fault_info.released_write;
      next_fsw[exc_pkg::FSW_RM]                     = fault_info.rmw;
      next_fsw[exc_pkg::FSW_IN]                     = fault_info.prefetch |
                                                      fault_info.multi_register_move_prefetch;
      next_fsw[exc_pkg::FSW_RW]                     = fault_info.read |
                                                      fault_info.prefetch |
                                                      fault_info.multi_register_move_prefetch;
      next_fsw[exc_pkg::FSW_LG]                     = fault_info.long_op;
      next_fsw[exc_pkg::FSW_SZH:exc_pkg::FSW_SZL]   = fault_info.size;
      next_fsw[exc_pkg::FSW_FCH:0]                  = fault_info.cycle_space_code;
    end
  end

  // Avalon slave: one wait state, read data registered in the first cycle
  assign next_bus_ack = (avs_read || avs_write) && !bus_ack;
  always_comb begin
    next_readdata = avs_readdata;
    if (avs_read && !bus_ack) begin
      case (avs_address)
        exc_pkg::REG_STATE:   next_readdata = {16'h0000, sr};
        exc_pkg::REG_SSP:     next_readdata = supervisor_stack_pointer;
        exc_pkg::REG_VERSION: next_readdata = {24'h00_0000, version};
        exc_pkg::REG_STATUS:  next_readdata = {16'h0000, push_frame.vector, nmi_pending,
                                               level, halted, state};
        exc_pkg::REG_FSW:     next_readdata = {16'h0000, fault_status_word};
        default:              next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state             <= exc_pkg::ST_IDLE;
      sr                <= exc_pkg::SR_RESET;
      supervisor_stack_pointer               <= exc_pkg::SSP_RESET;
      version           <= exc_pkg::VERSION_RST;
      pend_level        <= '0;
      push_frame        <= '0;
      frame             <= '0;
      rte_done          <= 1'b0;
      rte_result        <= exc_pkg::RES_NONE;
      restored_pc       <= '0;
      rerun_valid       <= 1'b0;
      rerun_cycle       <= '0;
      fault_status_word <= '0;
      nmi_pending       <= 1'b0;
      prev_level        <= '0;
      prev_mask         <= exc_pkg::SR_RESET[exc_pkg::SR_MASK_HI:exc_pkg::SR_MASK_LO];
      bus_ack           <= 1'b0;
      avs_readdata      <= '0;
    end else begin
      state             <= next_state;
      sr                <= next_sr;
      supervisor_stack_pointer               <= next_ssp;
      version           <= next_version;
      pend_level        <= next_pend_level;
      push_frame        <= next_push_frame;
      frame             <= next_frame;
      rte_done          <= next_rte_done;
      rte_result        <= next_rte_result;
      restored_pc       <= next_restored_pc;
      rerun_valid       <= next_rerun_valid;
      rerun_cycle       <= next_rerun_cycle;
      fault_status_word <= next_fsw;
      nmi_pending       <= next_nmi_pending;
      prev_level        <= level;
      prev_mask         <= mask;
      bus_ack           <= next_bus_ack;
      avs_readdata      <= next_readdata;
    end
  end

  // Handshake outputs
  assign iack_req             = (state == exc_pkg::ST_IACK);
  assign iack_space           = exc_pkg::IACK_SPACE;
  assign iack_level           = pend_level;
  assign push_valid           = (state == exc_pkg::ST_PUSH);
  assign rewrite_req          = (state == exc_pkg::ST_REWRITE);
  assign halted               = (state == exc_pkg::ST_HALT);
  assign processor_state_word = sr;
  assign avs_waitrequest      = (avs_read || avs_write) && !bus_ack;

  // ************************************************
  // Assertions
  // ************************************************
  a_filter_agree: assert property (@(posedge sys_clk) disable iff (!resetn)
    $changed(irq_filt) |-> $past(irq_s2) == $past(irq_s3))
    else $error("filtered request moved without agreement");
  a_mask_ignores: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == exc_pkg::ST_IDLE) && !nmi_pending && (level <= mask) |=>
    state != exc_pkg::ST_IACK)
    else $error("masked request was taken");
  a_entry_state: assert property (@(posedge sys_clk) disable iff (!resetn)
    take_irq |=> sr[exc_pkg::SR_S] && !sr[exc_pkg::SR_T1] && !sr[exc_pkg::SR_T0] &&
    (mask == pend_level) && (push_frame.sr == $past(sr)))
    else $error("entry state word wrong");
  a_iack_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    take_irq |=> iack_req && (iack_space == exc_pkg::IACK_SPACE) &&
    (iack_level == $past(nmi_pending ? exc_pkg::LEVEL_NMI : level)))
    else $error("acknowledge cycle level wrong");
  a_auto_vector: assert property (@(posedge sys_clk) disable iff (!resetn)
    iack_req && iack_done && iack_autovector && !iack_bus_fault |=>
    push_frame.vector == exc_pkg::VEC_AUTO_BASE + {5'h00, iack_level})
    else $error("autovector wrong");
  a_spurious_vec: assert property (@(posedge sys_clk) disable iff (!resetn)
    iack_req && iack_done && iack_bus_fault |=> push_valid &&
    (push_frame.vector == exc_pkg::VEC_SPURIOUS))
    else $error("spurious vector wrong");
  a_push_pc: assert property (@(posedge sys_clk) disable iff (!resetn)
    take_irq |=> push_frame.pc == $past(next_pc))
    else $error("stacked return address wrong");
  a_nmi_edge: assert property (@(posedge sys_clk) disable iff (!resetn)
    (level == exc_pkg::LEVEL_NMI) && (prev_level != exc_pkg::LEVEL_NMI) |=> nmi_pending)
    else $error("level seven edge missed");
  a_ret_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    rte_done && (rte_result == exc_pkg::RES_SIX) && $past(state == exc_pkg::ST_RTE) |->
    supervisor_stack_pointer == $past(supervisor_stack_pointer) + exc_pkg::STEP_SIX)
    else $error("six-word return step wrong");
  a_version_chk: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == exc_pkg::ST_RTE) && (frame.format == exc_pkg::FMT_FAULT) && frame.accessible &&
    (frame.word14[15:8] != version) |=> rte_result == exc_pkg::RES_FORMAT)
    else $error("version mismatch accepted");
  a_rewrite_halt: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == exc_pkg::ST_REWRITE) && rewrite_fault |=> halted [*2])
    else $error("rewrite fault did not halt");
  a_fsw_class: assert property (@(posedge sys_clk) disable iff (!resetn)
    fault_req |=> !fault_status_word[13] &&
    (fault_status_word[exc_pkg::FSW_TP] == $past(fault_info.exc_class)))
    else $error("fault status word class wrong");

endmodule : exception_frame_unit

/* File: tb/exc_partner.sv */
// Model of the interrupting peripherals and the stacking bus controller.
// Assumes the bench picks how each acknowledge cycle ends.
`timescale 1ns/1ps
module exc_partner (
  input  wire logic       sys_clk,
  input  wire logic       iack_req,
  input  wire logic       push_valid,
  input  wire logic [1:0] kind,
  output logic            iack_done,
  output logic            iack_autovector,
  output logic            iack_bus_fault,
  output logic [7:0]      iack_vector,
  output logic            push_ack
);
  initial {iack_done, iack_autovector, iack_bus_fault, iack_vector, push_ack} = '0;
  // End each acknowledge and push after one wait cycle
  always @(posedge sys_clk) begin
    iack_done       <= iack_req & ~iack_done;
    iack_autovector <= kind == 2'd1;
    iack_bus_fault  <= kind == 2'd2;
    iack_vector     <= iack_req ? 8'h0F : ~iack_vector;
    push_ack        <= push_valid & ~push_ack;
  end
endmodule : exc_partner

/* File: tb/exception_frame_unit_tb.sv */
// Self-checking bench for the exception entry and frame unit.
// Assumes the partner model answers acknowledge and push cycles.
`timescale 1ns/1ps
module exception_frame_unit_tb;
  logic sys_clk = 0, resetn = 0, at_boundary = 0, avs_read = 0, avs_write = 0;
  logic rte_req = 0, fault_req = 0, rewrite_done = 0, rewrite_fault = 0;
  logic [7:1] interrupt_request_lines = '0;
  logic [31:0] next_pc = 32'h0000_0400, avs_writedata = '0, avs_readdata, restored_pc;
  logic [4:0] avs_address = '0;
  logic [1:0] kind = '0;
  exc_pkg::rte_frame_s rte_frame = '0;
  exc_pkg::fault_info_s fault_info = '0;
  exc_pkg::push_frame_s push_frame;
  exc_pkg::rte_result_e rte_result;
  exc_pkg::rerun_cycle_s rerun_cycle;
  logic iack_req, iack_done, iack_autovector, iack_bus_fault, push_valid, push_ack;
  logic rte_done, rerun_valid, rewrite_req, halted, avs_waitrequest;
  logic [3:0] iack_space;
  logic [2:0] iack_level;
  logic [7:0] iack_vector;
  logic [15:0] fault_status_word, processor_state_word;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  exception_frame_unit uut (.*);
  exc_partner partner (.*);

  always #25 sys_clk = ~sys_clk;

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    if (s !== e)
      n_mismatch++;
  endtask : chk

  // One register access; a read compares against d
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, d);
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk);
  endtask : bus

  task automatic irq(input logic [2:0] l, input logic [1:0] k, input logic [7:0] v,
                     input logic [15:0] s);
    kind <= k;
    interrupt_request_lines <= 7'h01 << (l - 3'd1);
    at_boundary <= 1;
    do @(posedge sys_clk); while (iack_req !== 1'b1);
    chk(iack_level, l);
    chk(iack_space, 4'hF);
    at_boundary <= 0;
    do @(posedge sys_clk); while (iack_done !== 1'b1);
    interrupt_request_lines <= '0;
    do @(posedge sys_clk); while (push_ack !== 1'b1);
    chk(push_frame.vector, v);
    chk(push_frame.pc, next_pc);
    @(posedge sys_clk);
    chk(processor_state_word, s);
  endtask : irq

  task automatic exception_return_op(input logic [3:0] f, input logic a, input exc_pkg::rte_result_e r,
                     input logic [31:0] s);
    rte_frame <= '{f, 16'h2000, 32'h0000_0500, 16'h0000, 16'h0100, a};
    rte_req <= 1;
    repeat (2) @(posedge sys_clk);
    rte_req <= 0;
    @(posedge sys_clk);
    chk(rte_done, 1'b1);
    chk(rte_result, r);
    bus(0, exc_pkg::REG_SSP, s);
  endtask : exception_return_op

  task automatic flt(input exc_pkg::fault_info_s f, input logic [15:0] e);
    fault_info <= f;
    fault_req <= 1;
    @(posedge sys_clk);
    fault_req <= 0;
    repeat (2) @(posedge sys_clk);
    chk(fault_status_word, e);
    bus(0, exc_pkg::REG_FSW, {16'h0000, e});
  endtask : flt

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1;
    @(posedge sys_clk);
    bus(0, exc_pkg::REG_STATE, 32'h0000_2700);
    bus(0, exc_pkg::REG_VERSION, 32'h0000_0001);
    bus(0, 5'h1C, 32'h0000_0000);
    bus(1, exc_pkg::REG_SSP, 32'h0000_0100);
    bus(1, exc_pkg::REG_STATE, 32'h0000_E000);
    irq(3'd3, 2'd1, 8'h1B, 16'h2300);
    irq(3'd5, 2'd2, 8'h18, 16'h2500);
    irq(3'd7, 2'd0, 8'h0F, 16'h2700);
    bus(0, exc_pkg::REG_SSP, 32'h0000_00E8);
    $display("interrupt test done");
    exception_return_op(4'h0, 1'b1, exc_pkg::RES_FOUR, 32'h0000_00F0);
    chk(restored_pc, 32'h0000_0500);
    exception_return_op(4'h2, 1'b1, exc_pkg::RES_SIX, 32'h0000_00FC);
    exception_return_op(4'h5, 1'b1, exc_pkg::RES_FORMAT, 32'h0000_00F4);
    exception_return_op(4'hC, 1'b1, exc_pkg::RES_FAULT, 32'h0000_010C);
    exception_return_op(4'hC, 1'b0, exc_pkg::RES_BUSERR, 32'h0000_00F4);
    $display("return test done");
    flt(16'h8BAE, 16'h9A75);
    flt(16'h2000, 16'h40C0);
    flt(16'h1470, 16'h01CE);
    $display("fault word test done");
    wrap_up();
  end
endmodule : exception_frame_unit_tb
